// ### rtl/position_corrector_pkg.sv
// package for the feedback position corrector: register map, mode bits,
// table geometry and state encodings.
// assumes a 16-bit register port and a 16-bit raw feedback position word.
package position_corrector_pkg;

    // ------------------------------------------------------------
    // widths and geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int ENTRIES = 16;
    localparam int SECTOR_MSB = 15; // top four bits pick the 1/16 turn
    localparam int SECTOR_LSB = 12;

    // ------------------------------------------------------------
    // register offsets (word index on the register port)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ACTIVE_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] ALTERNATE_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] SPEED_ERR_ADDR = 6'h20;
    localparam logic [ADDR_W-1:0] POS_ERR_ADDR = 6'h21;
    localparam logic [ADDR_W-1:0] SWAP_CTRL_ADDR = 6'h22;
    localparam logic [ADDR_W-1:0] MODE_ADDR = 6'h23;

    // ------------------------------------------------------------
    // feedback mode register fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_CORR_BIT = 2;
    localparam int MODE_MEAS_BIT = 3;
    localparam logic [DATA_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ENTRY_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

    // learning gain: correction entry moves by -(error >>> this shift)
    localparam int LEARN_SHIFT = 4;

    typedef enum logic [2:0] {
        MEAS_IDLE = 3'b001,
        MEAS_TRACK = 3'b010,
        MEAS_UPDATE = 3'b100
    } meas_state_t;

endpackage

// ### rtl/feedback_position_corrector.sv
// feedback position corrector: sixteen-entry correction table with an
// alternate bank, measurement mode that learns the table, register port.
// assumes rawPos is a synchronous word from the feedback interface on clk
// and that the angle stage downstream takes corrPos.
//
// Overview of operation
// - The table is applied only while mode bit 2 is set.
// - While mode bit 3 is set the block learns and writes the table itself.
// - The correction is added to the raw position before the angle stage.
// - No correction is applied while the input is in high-resolution mode.
// - Writing entry 34 exchanges the active and alternate sixteen entries.
// - Entry 32 reports integrated speed error, valid only while measuring.
// - Entry 33 reports integrated position error, valid only while measuring.
`timescale 1ns/100ps
module feedback_position_corrector (
    input wire logic clk, // 250 MHz system clock
    input wire logic rst, // synchronous, active high
    input wire logic [position_corrector_pkg::ADDR_W-1:0] regAddr, // index
    input wire logic [position_corrector_pkg::DATA_W-1:0] regWdata, // data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [position_corrector_pkg::DATA_W-1:0] regRdata, // read data
    input wire logic [position_corrector_pkg::DATA_W-1:0] rawPos, // raw pos
    input wire logic rawValid, // one-cycle new sample
    input wire logic highResMode, // feedback in high-resolution mode
    output logic [position_corrector_pkg::DATA_W-1:0] corrPos, // corrected
    output logic corrValid // corrPos updated
);
    import position_corrector_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] activeTab_reg [ENTRIES]; // used for correction
    logic [DATA_W-1:0] altTab_reg [ENTRIES]; // storage only
    logic [DATA_W-1:0] mode_reg;
    logic [DATA_W-1:0] swapCtrl_reg;
    logic [DATA_W-1:0] speedErr_reg;
    logic [DATA_W-1:0] posErr_reg;
    logic [DATA_W-1:0] prevPos_reg;
    logic [DATA_W-1:0] avgStep_reg;
    logic [DATA_W-1:0] expPos_reg;
    logic [3:0] learnIdx_reg;
    logic signed [DATA_W-1:0] learnDelta_reg;
    meas_state_t measState_reg;
    meas_state_t measState_next;

    logic corrEn;
    logic measEn;
    logic wrActive;
    logic wrAlt;
    logic swapReq;
    logic [3:0] sector;
    logic [DATA_W-1:0] step;
    logic signed [DATA_W-1:0] stepErr;
    logic signed [DATA_W-1:0] pErr;
    logic learnWr;

    assign corrEn = mode_reg[MODE_CORR_BIT] && !highResMode;
    assign measEn = mode_reg[MODE_MEAS_BIT];
    assign wrActive = regWr && (regAddr[5:4] == ACTIVE_BASE[5:4]);
    assign wrAlt = regWr && (regAddr[5:4] == ALTERNATE_BASE[5:4]);
    assign swapReq = regWr && (regAddr == SWAP_CTRL_ADDR);
    assign sector = rawPos[SECTOR_MSB:SECTOR_LSB];
    assign learnWr = (measState_reg == MEAS_UPDATE);

    // ------------------------------------------------------------
    // correction tables and bank swap
    // ------------------------------------------------------------
    // a swap wins over any learning update in the same cycle; the entry
    // learned in that cycle is simply dropped and relearned next turn
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                activeTab_reg[i] <= ENTRY_RESET;
                altTab_reg[i] <= ENTRY_RESET;
            end
        end else if (swapReq) begin
            for (int i = 0; i < ENTRIES; i++) begin
                activeTab_reg[i] <= altTab_reg[i];
                altTab_reg[i] <= activeTab_reg[i];
            end
        end else begin
            if (wrActive) begin
                activeTab_reg[regAddr[3:0]] <= regWdata;
            end else if (learnWr) begin
                activeTab_reg[learnIdx_reg] <=
                    activeTab_reg[learnIdx_reg] + learnDelta_reg;
            end
            if (wrAlt) begin
                altTab_reg[regAddr[3:0]] <= regWdata;
            end
        end
    end

    // ------------------------------------------------------------
    // mode and swap control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= MODE_RESET;
            swapCtrl_reg <= ENTRY_RESET;
        end else begin
            if (regWr && regAddr == MODE_ADDR) begin
                mode_reg <= regWdata;
            end
            if (swapReq) begin
                swapCtrl_reg <= regWdata;
            end
        end
    end

    // ------------------------------------------------------------
    // corrected position output
    // ------------------------------------------------------------
    // correction is added ahead of the angle stage, so downstream never
    // sees the raw word while corrEn is set (mode bit 2 set, not in high-resolution mode)
    always_ff @(posedge clk) begin
        if (rst) begin
            corrPos <= ENTRY_RESET;
            corrValid <= 1'b0;
        end else begin
            corrValid <= rawValid;
            if (rawValid) begin
                corrPos <= corrEn ? rawPos + activeTab_reg[sector]
                                  : rawPos;
            end
        end
    end

    // ------------------------------------------------------------
    // measurement: track speed and position error per sector
    // ------------------------------------------------------------
    // the learner assumes constant speed: the mean step is the reference,
    // any deviation is blamed on the sector the sample fell into
    assign step = rawPos - prevPos_reg;
    assign stepErr = signed'(step - avgStep_reg);
    assign pErr = signed'(rawPos + activeTab_reg[sector] - expPos_reg);

    always_comb begin
        measState_next = measState_reg;
        case (measState_reg)
            MEAS_IDLE: begin
                if (measEn && rawValid) begin
                    measState_next = MEAS_TRACK;
                end
            end
            MEAS_TRACK: begin
                if (!measEn) begin
                    measState_next = MEAS_IDLE;
                end else if (rawValid) begin
                    measState_next = MEAS_UPDATE;
                end
            end
            MEAS_UPDATE: begin
                measState_next = measEn ? MEAS_TRACK : MEAS_IDLE;
            end
            default: begin
                measState_next = MEAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            measState_reg <= MEAS_IDLE;
        end else begin
            measState_reg <= measState_next;
        end
    end

    // error integrators, cleared when measurement is off
    always_ff @(posedge clk) begin
        if (rst) begin
            prevPos_reg <= ENTRY_RESET;
            avgStep_reg <= ENTRY_RESET;
            expPos_reg <= ENTRY_RESET;
            speedErr_reg <= ENTRY_RESET;
            posErr_reg <= ENTRY_RESET;
            learnIdx_reg <= 4'h0;
            learnDelta_reg <= '0;
        end else if (!measEn) begin
            speedErr_reg <= ENTRY_RESET;
            posErr_reg <= ENTRY_RESET;
            prevPos_reg <= rawPos;
        end else if (rawValid) begin
            prevPos_reg <= rawPos;
            if (measState_reg == MEAS_IDLE) begin
                expPos_reg <= rawPos;
            end else begin
                avgStep_reg <= avgStep_reg +
                    DATA_W'(stepErr >>> LEARN_SHIFT);
                expPos_reg <= expPos_reg + avgStep_reg;
                speedErr_reg <= speedErr_reg + stepErr;
                posErr_reg <= posErr_reg + pErr;
                learnIdx_reg <= sector;
                learnDelta_reg <= -(pErr >>> LEARN_SHIFT);
            end
        end
    end

    // ------------------------------------------------------------
    // register read port: data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= UNMAPPED_READ;
        end else if (regRd) begin
            if (regAddr[5:4] == ACTIVE_BASE[5:4]) begin
                regRdata <= activeTab_reg[regAddr[3:0]];
            end else if (regAddr[5:4] == ALTERNATE_BASE[5:4]) begin
                regRdata <= altTab_reg[regAddr[3:0]];
            end else if (regAddr == SPEED_ERR_ADDR) begin
                regRdata <= speedErr_reg;
            end else if (regAddr == POS_ERR_ADDR) begin
                regRdata <= posErr_reg;
            end else if (regAddr == SWAP_CTRL_ADDR) begin
                regRdata <= swapCtrl_reg;
            end else if (regAddr == MODE_ADDR) begin
                regRdata <= mode_reg;
            end else begin
                regRdata <= UNMAPPED_READ;
            end
        end
    end

endmodule

// ### verification/feedback_sensor_model.sv
// feedback source: constant-speed turning with a sector error, or one
// sample on request. assumes shot is a one-cycle pulse.
`timescale 1ns/100ps
module feedback_sensor_model (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic run, // turn at constant speed
    input wire logic shot, // send one sample
    input wire logic [15:0] shotPos, // its value
    output logic [15:0] rawPos, // sample word
    output logic rawValid // sample strobe
);
    logic [15:0] angle;
    logic [1:0] tick;
    // a sample every fourth cycle
    always_ff @(posedge clk) tick <= rst ? 2'd0 : tick + 2'd1;
    // odd sectors read high, so the corrector has something to learn
    always_ff @(posedge clk) begin
        if (rst) begin
            angle <= '0;
            rawPos <= '0;
            rawValid <= 1'b0;
        end else if (shot) begin
            rawPos <= shotPos;
            rawValid <= 1'b1;
        end else if (run && tick == 2'd3) begin
            angle <= angle + 16'h0040;
            rawPos <= angle + {4'h0, angle[12], 11'h000};
            rawValid <= 1'b1;
        end else begin
            rawPos <= ~rawPos; // word is inverted every cycle between samples
            rawValid <= 1'b0;
        end
    end
endmodule

// ### verification/position_corrector_monitor.sv
// checker on the corrector ports; mirrors the mode and swap words
// from the register writes it sees.
`timescale 1ns/100ps
module position_corrector_monitor
import position_corrector_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic [5:0] regAddr, // index
    input wire logic [15:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [15:0] regRdata, // read data
    input wire logic [15:0] rawPos, // raw position
    input wire logic rawValid, // sample strobe
    input wire logic highResMode, // high resolution
    input wire logic [15:0] corrPos, // corrected
    input wire logic corrValid // corrected strobe
);
    logic [15:0] modeReg;
    logic [15:0] swapReg;
    // shadow copies, since the design keeps them inside
    always_ff @(posedge clk) begin
        if (rst) begin
            modeReg <= '0;
            swapReg <= '0;
        end else if (regWr && regAddr == MODE_ADDR) begin
            modeReg <= regWdata;
        end else if (regWr && regAddr == SWAP_CTRL_ADDR) begin
            swapReg <= regWdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_valid_follows: assert property (rawValid |=> corrValid)
        else $error("corrValid missing after a sample");
    chk_valid_cause: assert property (corrValid |-> $past(rawValid))
        else $error("corrValid without a sample");
    chk_corr_off: assert property (rawValid && !modeReg[MODE_CORR_BIT]
        |=> corrPos == $past(rawPos)) else $error("corrected while off");
    chk_hires_raw: assert property (rawValid && highResMode
        |=> corrPos == $past(rawPos)) else $error("corrected in hi-res");
    chk_swap_readback: assert property (regRd && regAddr == SWAP_CTRL_ADDR
        |=> regRdata == swapReg) else $error("swap word lost");
    chk_unmapped_zero: assert property (regRd && regAddr > MODE_ADDR
        |=> regRdata == 16'h0000) else $error("unmapped read not 0");
    chk_speed_err: assert property (regRd && regAddr == SPEED_ERR_ADDR
        && !modeReg[MODE_MEAS_BIT] && !$past(modeReg[MODE_MEAS_BIT])
        |=> regRdata == 16'h0000) else $error("speed error kept");
    chk_pos_err: assert property (regRd && regAddr == POS_ERR_ADDR
        && !modeReg[MODE_MEAS_BIT] && !$past(modeReg[MODE_MEAS_BIT])
        |=> regRdata == 16'h0000) else $error("position error kept");
    chk_rdata_hold: assert property (!$past(regRd) |-> $stable(regRdata))
        else $error("read data moved without a read");
    cover property (rawValid && modeReg[MODE_CORR_BIT]);
    cover property (regWr && regAddr == SWAP_CTRL_ADDR);
    cover property (rawValid && modeReg[MODE_MEAS_BIT]);
endmodule
bind feedback_position_corrector position_corrector_monitor mon (.clk,
    .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .rawPos,
    .rawValid, .highResMode, .corrPos, .corrValid);

// ### verification/tb.sv
// register and sample-path tests for the corrector with a sensor model.
// assumes the register map and mode bits of position_corrector_pkg.
`timescale 1ns/100ps
module tb;
    import position_corrector_pkg::*;
    logic clk, rst, regWr, regRd, highResMode, run, shot, rawValid;
    logic corrValid, changed;
    logic [5:0] regAddr;
    logic [15:0] regWdata, regRdata, rawPos, corrPos, shotPos, rdv, live;
    logic [15:0] act [16], alt [16], snap [16];
    int miscompares = 0, tests_run = 0;
    feedback_position_corrector dut (.clk, .rst, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .rawPos, .rawValid, .highResMode,
        .corrPos, .corrValid);
    feedback_sensor_model sensor (.clk, .rst, .run, .shot, .shotPos,
        .rawPos, .rawValid);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input string what, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // read data appear in the cycle after the strobe and hold until the next read
    task rd(input logic [5:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        rdv = regRdata;
    endtask
    task rdc(input logic [5:0] a, input logic [15:0] exp);
        rd(a);
        chk($sformatf("word %h", a), exp, rdv);
    endtask
    task smp(input logic [15:0] p, exp);
        @(posedge clk);
        shot <= 1'b1;
        shotPos <= p;
        @(posedge clk);
        shot <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk("corrPos", exp, corrPos);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the tests need about 9000 cycles
    initial begin
        #(4 * 30000);
        miscompares++;
        stop_test;
    end
    initial begin
        {rst, regWr, regRd, highResMode, run, shot} = 6'b100000;
        {regAddr, regWdata, shotPos} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i <= 36; i++) rdc(i[5:0], 16'h0000);
        rdc(6'h3F, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            act[i] = 16'h0111 * i[15:0] - 16'h0400;
            alt[i] = 16'h8001 + i[15:0];
            wr(ACTIVE_BASE + i[5:0], act[i]);
            wr(ALTERNATE_BASE + i[5:0], alt[i]);
        end
        for (int i = 0; i < 16; i++) begin
            rdc(ACTIVE_BASE + i[5:0], act[i]);
            rdc(ALTERNATE_BASE + i[5:0], alt[i]);
        end
        $display("test table done");
        smp(16'h3123, 16'h3123);
        wr(MODE_ADDR, 16'h0004);
        for (int k = 0; k < 16; k++)
            smp({k[3:0], 12'h0A5}, {k[3:0], 12'h0A5} + act[k]);
        @(posedge clk) highResMode <= 1'b1;
        smp(16'h5000, 16'h5000);
        @(posedge clk) highResMode <= 1'b0;
        $display("test correction done");
        wr(SWAP_CTRL_ADDR, 16'h0001);
        rdc(SWAP_CTRL_ADDR, 16'h0001);
        for (int i = 0; i < 16; i++) begin
            rdc(ACTIVE_BASE + i[5:0], alt[i]);
            rdc(ALTERNATE_BASE + i[5:0], act[i]);
        end
        smp(16'h2000, 16'h2000 + alt[2]);
        wr(SWAP_CTRL_ADDR, 16'h0000);
        rdc(SWAP_CTRL_ADDR, 16'h0000);
        rdc(ACTIVE_BASE, act[0]);
        wr(SPEED_ERR_ADDR, 16'h1234);
        rdc(SPEED_ERR_ADDR, 16'h0000);
        $display("test swap done");
        for (int i = 0; i < 16; i++) begin
            rdc(i[5:0], act[i]);
            snap[i] = rdv;
        end
        wr(MODE_ADDR, 16'h000C);
        @(posedge clk) run <= 1'b1;
        repeat (8200) @(posedge clk);
        // learned values are not fixed, so only ask that the errors and the table entries move
        rd(SPEED_ERR_ADDR);
        live = rdv;
        rd(POS_ERR_ADDR);
        changed = (live | rdv) != 16'h0000;
        chk("errors live", 16'h0001, {15'h0000, changed});
        wr(MODE_ADDR, 16'h0004);
        changed = 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd(i[5:0]);
            changed |= (rdv !== snap[i]);
            snap[i] = rdv;
        end
        chk("learned", 16'h0001, {15'h0000, changed});
        // keep turning with learning off: the table must now stay put
        repeat (400) @(posedge clk);
        @(posedge clk) run <= 1'b0;
        for (int i = 0; i < 16; i++) rdc(i[5:0], snap[i]);
        rdc(SPEED_ERR_ADDR, 16'h0000);
        rdc(POS_ERR_ADDR, 16'h0000);
        $display("test measure done");
        stop_test;
    end
endmodule
